// ===== pkg/wdat_pkg.sv
package wdat_pkg;
  localparam logic [7:0] WDAT_ADDR_CONTROL = 8'h34;
  localparam logic [7:0] WDAT_ADDR_CODE = 8'h35;
  localparam logic [7:0] WDAT_CODE_CLEAR = 8'h4e;
  localparam logic [7:0] WDAT_CODE_DISABLE = 8'hb1;
  localparam logic [7:0] WDAT_CODE_TRAP_ARM = 8'hd2;
  // Control register field positions
  localparam int WDAT_BIT_OUT_SEL = 0;
  localparam int WDAT_BIT_TIME_LO = 1;
  localparam int WDAT_BIT_ENABLE = 3;
  localparam int WDAT_BIT_TRAP_ACT = 4;
  localparam int WDAT_BIT_RAM_TRAP = 5;
  localparam logic [1:0] WDAT_TIME_RESET = 2'h0;
  // Divider taps: binary counter is two stages, so the divider supplies period/4
  localparam int WDAT_DIV_WIDTH = 23;
  localparam int WDAT_TAP_FAST_MAX = 22;
  localparam int WDAT_TAP_SLOW_MAX = 14;
  localparam logic [4:0] WDAT_RESET_PULSE = 5'h18;
  // Fetch area kinds reported by the core
  typedef enum logic [1:0] {WDAT_AREA_ROM, WDAT_AREA_RAM, WDAT_AREA_SFR, WDAT_AREA_DBG} wdat_area_t;
endpackage

// ===== pkg/wdat_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wdat_if;
  import wdat_pkg::*;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic fetch_valid;
  wdat_area_t fetch_area;
  logic halt_count;
  logic prescale_source_select;
  logic overflow_interrupt;
  logic fetch_trap_interrupt;
  logic reset_req;
  logic reset_pin_oe;
  modport dev (input wr_en, wr_addr, wr_data, fetch_valid, fetch_area, halt_count,
    prescale_source_select, output overflow_interrupt, fetch_trap_interrupt, reset_req,
    reset_pin_oe);
  modport core (output wr_en, wr_addr, wr_data, fetch_valid, fetch_area, halt_count,
    prescale_source_select, input overflow_interrupt, fetch_trap_interrupt, reset_req,
    reset_pin_oe);
endinterface
`default_nettype wire

// ===== rtl/wdat_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module wdat_watchdog
  import wdat_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link to the core
  wdat_if.dev bus
);
  logic out_sel_reg;
  logic [1:0] time_reg;
  logic enable_reg;
  logic trap_act_reg;
  logic ram_trap_pend_reg;
  logic ram_trap_reg;
  logic en_written_reg;
  logic [WDAT_DIV_WIDTH-1:0] div_reg;
  logic tap_prev_reg;
  logic [1:0] bin_reg;
  logic [4:0] pulse_reg;
  logic ovf_irq_reg;
  logic trap_irq_reg;
  logic wr_ctl;
  logic wr_code;
  logic tap;
  logic tick;
  logic overflow;
  logic trap_hit;
  logic count_on;

  function automatic int tap_index(input logic slow, input logic [1:0] sel);
    tap_index = (slow ? WDAT_TAP_SLOW_MAX : WDAT_TAP_FAST_MAX) - 2 * int'(sel);
  endfunction

  assign wr_ctl = bus.wr_en && (bus.wr_addr == WDAT_ADDR_CONTROL);
  assign wr_code = bus.wr_en && (bus.wr_addr == WDAT_ADDR_CODE);
  assign count_on = enable_reg && !bus.halt_count;
  assign tap = div_reg[tap_index(bus.prescale_source_select, time_reg)];
  assign tick = count_on && tap_prev_reg && !tap;
  assign overflow = tick && (bin_reg == 2'h3);
  assign trap_hit = bus.fetch_valid && (bus.fetch_area == WDAT_AREA_SFR ||
    bus.fetch_area == WDAT_AREA_DBG || (bus.fetch_area == WDAT_AREA_RAM && ram_trap_reg));

  // ----------------------------------------
  // Control register (write-only, no read path)
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_sel_reg <= 1'b1;
      time_reg <= WDAT_TIME_RESET;
      enable_reg <= 1'b1;
      trap_act_reg <= 1'b1;
      ram_trap_pend_reg <= 1'b1;
    end
    else if (wr_ctl)
    begin
      out_sel_reg <= out_sel_reg & bus.wr_data[WDAT_BIT_OUT_SEL];
      time_reg <= bus.wr_data[WDAT_BIT_TIME_LO +: 2];
      trap_act_reg <= bus.wr_data[WDAT_BIT_TRAP_ACT];
      ram_trap_pend_reg <= bus.wr_data[WDAT_BIT_RAM_TRAP];
      // Enable is only set here; clearing it needs the disable code as well
      if (bus.wr_data[WDAT_BIT_ENABLE])
        enable_reg <= 1'b1;
    end
    else if (wr_code && bus.wr_data == WDAT_CODE_DISABLE && !en_written_reg)
      enable_reg <= 1'b0;
  end

  // Enable bit as written, kept apart so the disable code can check it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      en_written_reg <= 1'b1;
    else if (wr_ctl)
      en_written_reg <= bus.wr_data[WDAT_BIT_ENABLE];
  end

  // ----------------------------------------
  // Code port
  // ----------------------------------------
  logic disabled_reg;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      disabled_reg <= 1'b0;
    else if (wr_ctl && bus.wr_data[WDAT_BIT_ENABLE])
      disabled_reg <= 1'b0;
    else if (wr_code && bus.wr_data == WDAT_CODE_DISABLE && !en_written_reg)
      disabled_reg <= 1'b1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ram_trap_reg <= 1'b1;
    else if (wr_code && bus.wr_data == WDAT_CODE_TRAP_ARM)
      ram_trap_reg <= ram_trap_pend_reg;
  end

  // ----------------------------------------
  // Divider and binary counter
  // ----------------------------------------
  // Divider is cleared only by reset, not by the clear code, and stops on halt_count, so the first overflow may come early
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_reg <= '0;
      tap_prev_reg <= 1'b0;
    end
    else if (!bus.halt_count)
    begin
      div_reg <= div_reg + 1'b1;
      tap_prev_reg <= tap;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      bin_reg <= 2'h0;
    else if (disabled_reg)
      bin_reg <= 2'h0;
    else if (wr_code && bus.wr_data == WDAT_CODE_CLEAR)
      bin_reg <= 2'h0;
    else if (tick)
      bin_reg <= bin_reg + 2'h1;
  end

  // ----------------------------------------
  // Interrupt pulses and reset request
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ovf_irq_reg <= 1'b0;
      trap_irq_reg <= 1'b0;
    end
    else
    begin
      ovf_irq_reg <= overflow && !disabled_reg && !out_sel_reg;
      trap_irq_reg <= trap_hit && !trap_act_reg;
    end
  end

  // Pulse is counted out in clk cycles; the system reset then clears this block too
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pulse_reg <= 5'h0;
    else if (pulse_reg != 5'h0)
      pulse_reg <= pulse_reg - 5'h1;
    // A request inside a running pulse is dropped, so the pulse never passes 24
    else if ((overflow && !disabled_reg && out_sel_reg) || (trap_hit && trap_act_reg))
      pulse_reg <= WDAT_RESET_PULSE;
  end

  assign bus.overflow_interrupt = ovf_irq_reg;
  assign bus.fetch_trap_interrupt = trap_irq_reg;
  assign bus.reset_req = (pulse_reg != 5'h0);
  assign bus.reset_pin_oe = (pulse_reg != 5'h0);
endmodule // wdat_watchdog
`default_nettype wire

// ===== rtl/wdat_core_end.sv
`timescale 1ns/1ps
`default_nettype none
module wdat_core_end
  import wdat_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // User side: register writes
  input wire logic usr_wr_en,
  input wire logic [7:0] usr_wr_addr,
  input wire logic [7:0] usr_wr_data,
  // User side: fetches and modes
  input wire logic usr_fetch_valid,
  input wire logic [1:0] usr_fetch_area,
  input wire logic usr_halt,
  input wire logic usr_slow,
  // User side: events
  output logic usr_nmi_overflow,
  output logic usr_nmi_trap,
  output logic usr_reset_pin_low,
  // Link to the watchdog
  wdat_if.core bus
);
  // Software keeps the disable order and clear spacing itself
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus.wr_en <= 1'b0;
      bus.wr_addr <= 8'h00;
      bus.wr_data <= 8'h00;
      bus.fetch_valid <= 1'b0;
      bus.fetch_area <= WDAT_AREA_ROM;
      bus.halt_count <= 1'b0;
      bus.prescale_source_select <= 1'b0;
    end
    else
    begin
      bus.wr_en <= usr_wr_en;
      bus.wr_addr <= usr_wr_addr;
      bus.wr_data <= usr_wr_data;
      bus.fetch_valid <= usr_fetch_valid;
      bus.fetch_area <= wdat_area_t'(usr_fetch_area);
      bus.halt_count <= usr_halt;
      bus.prescale_source_select <= usr_slow;
    end
  end

  // Non-maskable: passed on with no master flag gating
  assign usr_nmi_overflow = bus.overflow_interrupt;
  assign usr_nmi_trap = bus.fetch_trap_interrupt;
  assign usr_reset_pin_low = bus.reset_pin_oe;
endmodule // wdat_core_end
`default_nettype wire

// ===== verif/wdat_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module wdat_monitor
  import wdat_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link signals
  input wire logic fetch_valid,
  input wire wdat_area_t fetch_area,
  input wire logic halt_count,
  input wire logic overflow_interrupt,
  input wire logic fetch_trap_interrupt,
  input wire logic reset_req,
  input wire logic reset_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----
  // Reset pulse length
  // ----
  logic [5:0] hi_reg;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      hi_reg <= 6'h00;
    else
      hi_reg <= reset_req ? hi_reg + 6'h01 : 6'h00;
  end
  a_ovf_irq_pulse: assert property (overflow_interrupt |=> !overflow_interrupt)
    else $error("overflow irq wider than one cycle");
  a_trap_irq_pulse: assert property (fetch_trap_interrupt |=> !fetch_trap_interrupt)
    else $error("trap irq wider than one cycle");
  a_pin_tracks_req: assert property (reset_pin_oe == reset_req)
    else $error("reset pin differs from request");
  a_area_traps: assert property (fetch_valid && fetch_area inside {WDAT_AREA_SFR, WDAT_AREA_DBG}
    |=> fetch_trap_interrupt || reset_req)
    else $error("register area fetch did not trap");
  a_trap_has_cause: assert property (fetch_trap_interrupt
    |-> $past(fetch_valid) && $past(fetch_area) != WDAT_AREA_ROM)
    else $error("trap irq without trapping fetch");
  a_reset_max_len: assert property (reset_req |-> hi_reg < 6'h18)
    else $error("reset longer than 24 cycles");
  a_reset_holds: assert property ($rose(reset_req) |-> reset_req [*8])
    else $error("reset pulse cut short");
  a_halt_quiet: assert property (halt_count && $past(halt_count) |-> !overflow_interrupt)
    else $error("overflow while halted");
endmodule // wdat_monitor
`default_nettype wire

// ===== verif/tb_watchdog_with_address_trap.sv
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_with_address_trap;
  import wdat_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic we = 1'b0;
  logic [7:0] wa = 8'h00;
  logic [7:0] wd = 8'h00;
  logic fv = 1'b0;
  logic [1:0] fa = 2'h0;
  logic halt = 1'b0;
  logic slow = 1'b1;
  logic irq;
  logic trp;
  logic rpin;
  int failures = 0;
  int n_checks = 0;
  int i, t, r, f;
  wdat_if bus ();
  always #5 clk = ~clk;
  wdat_watchdog wdat_watchdog_inst (.clk(clk), .resetn(resetn), .bus(bus.dev));
  // Only the shortest slow period fits the run; the shortest fast tap is checked for silence
  wdat_core_end wdat_core_end_inst (.clk(clk), .resetn(resetn), .usr_wr_en(we),
    .usr_wr_addr(wa), .usr_wr_data(wd), .usr_fetch_valid(fv), .usr_fetch_area(fa),
    .usr_halt(halt), .usr_slow(slow), .usr_nmi_overflow(irq), .usr_nmi_trap(trp),
    .usr_reset_pin_low(rpin), .bus(bus.core));
  wdat_monitor wdat_monitor_inst (.clk(clk), .resetn(resetn), .fetch_valid(bus.fetch_valid),
    .fetch_area(bus.fetch_area), .halt_count(bus.halt_count),
    .overflow_interrupt(bus.overflow_interrupt), .fetch_trap_interrupt(bus.fetch_trap_interrupt),
    .reset_req(bus.reset_req), .reset_pin_oe(bus.reset_pin_oe));
  // ----
  // Helpers
  // ----
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task rst();
    @(posedge clk);
    #1 resetn = 1'b0;
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 we = 1'b1;
    wa = a;
    wd = d;
    @(posedge clk);
    #1 we = 1'b0;
  endtask
  // Counts event cycles over n clocks; f is the first overflow or reset cycle
  task watch(input int n);
    i = 0;
    t = 0;
    r = 0;
    f = -1;
    for (int k = 0; k < n; k++)
    begin
      @(negedge clk);
      // Interrupts are only counted, never answered by a clear
      i += irq;
      t += trp;
      r += rpin;
      if ((irq || rpin) && f < 0)
        f = k;
    end
  endtask
  task fetch(input logic [1:0] a, input int et, input int er);
    @(posedge clk);
    #1 fv = 1'b1;
    fa = a;
    @(posedge clk);
    #1 fv = 1'b0;
    watch(30);
    chk(t, et);
    chk(r, er);
  endtask
  // ----
  // Scenarios
  // ----
  task s_fast();
    @(posedge clk);
    #1 slow = 1'b0;
    rst();
    wr(8'h34, 8'h3f);
    wr(8'h35, 8'h4e);
    watch(2200);
    chk(i + r, 0);
    @(posedge clk);
    #1 slow = 1'b1;
  endtask
  task s_reset();
    rst();
    wr(8'h34, 8'h3f);
    wr(8'h35, 8'h4e);
    watch(2200);
    chk(i, 0);
    chk(r, 24);
    chk(f >= 1530 && f <= 2060, 1);
  endtask
  task s_irq();
    rst();
    wr(8'h34, 8'h3e);
    wr(8'h34, 8'h3f);
    wr(8'h35, 8'h4e);
    watch(2200);
    chk(i, 1);
    chk(r, 0);
    wr(8'h35, 8'h4e);
    @(posedge clk);
    #1 halt = 1'b1;
    watch(3000);
    chk(i, 0);
    @(posedge clk);
    #1 halt = 1'b0;
    wr(8'h35, 8'h4e);
    watch(2100);
    chk(f > 1850 && f < 1950 && i == 1, 1);
  endtask
  task s_disable();
    rst();
    wr(8'h34, 8'h3e);
    wr(8'h35, 8'hb1);
    wr(8'h35, 8'h55);
    watch(2200);
    chk(i, 1);
    wr(8'h35, 8'h4e);
    wr(8'h34, 8'h36);
    wr(8'h35, 8'hb1);
    watch(3000);
    chk(i, 0);
  endtask
  task s_trap();
    rst();
    wr(8'h34, 8'h2e);
    wr(8'h35, 8'hd2);
    fetch(2'h1, 1, 0);
    fetch(2'h2, 1, 0);
    fetch(2'h3, 1, 0);
    fetch(2'h0, 0, 0);
    wr(8'h34, 8'h0e);
    fetch(2'h1, 1, 0);
    wr(8'h35, 8'hd2);
    fetch(2'h1, 0, 0);
    wr(8'h34, 8'h1e);
    wr(8'h35, 8'hd2);
    fetch(2'h2, 0, 24);
  endtask
  initial
  begin
    s_fast();
    s_reset();
    s_irq();
    s_disable();
    s_trap();
    summarize();
  end
  initial
  begin
    #1000000;
    failures++;
    summarize();
  end
endmodule // tb_watchdog_with_address_trap
`default_nettype wire
